// ===== hdl/ispa_regs.vh
// Constants of the peripheral byte space: pointer offsets, fields and reset values.
`ifndef ISPA_REGS_VH
`define ISPA_REGS_VH

// Word base pointers of the mapped registers in the 256-byte space.
`define ISPA_PTR_WADDR 8'h00
`define ISPA_PTR_WDATA 8'h04
`define ISPA_PTR_RADDR 8'h10
`define ISPA_PTR_RDATA 8'h14
`define ISPA_PTR_ACC_STAT 8'h20
`define ISPA_PTR_ACC_CTRL 8'h24
`define ISPA_PTR_SUMMARY 8'h80
`define ISPA_PTR_ENABLES 8'h84
`define ISPA_PTR_MBOX_OUT 8'h90
`define ISPA_PTR_MBOX_IN 8'h94

// Special byte pointers that change the pointer walk, start bus cycles or move the mailbox full flags.
`define ISPA_PTR_WDATA_MSB 8'h07
`define ISPA_PTR_RDATA_MSB 8'h17
`define ISPA_PTR_MBOX_OUT_MSB 8'h93
`define ISPA_PTR_MBOX_IN_MSB 8'h97
`define ISPA_PTR_LAST 8'hFF
`define ISPA_PTR_FIRST 8'h00
`define ISPA_PTR_STEP 8'h01

// Reset values.
`define ISPA_RST_WORD 32'h0000_0000
`define ISPA_RST_BYTE 8'h00
`define ISPA_UNMAPPED_BYTE 8'h00

// Field positions inside the external access status word.
`define ISPA_AS_ALERT 0
`define ISPA_AS_IN_FULL 1
`define ISPA_AS_OUT_FULL 2
`define ISPA_AS_PTR_LSB 8

// Byte lane layout of a 32-bit register and the word alignment mask.
`define ISPA_LANES 4
`define ISPA_LANE_ONE 4'h1
`define ISPA_LANE_NONE 4'h0
`define ISPA_ALIGN_MASK 32'hFFFF_FFFC

`endif

// ===== hdl/ispa_word.v
// A 32-bit register written one byte lane at a time or loaded as a whole word.
`timescale 1ns/100ps
`include "ispa_regs.vh"

module ispa_word (
  input wire clk,
  input wire rst,
  input wire [3:0] lane_we,
  input wire [7:0] byte_in,
  input wire word_we,
  input wire [31:0] word_in,
  output wire [31:0] q
);

  reg [31:0] word;

  assign q = word;

  // Each lane takes its byte; a whole-word load wins over a lane write.
  genvar g;
  generate
    for (g = 0; g < `ISPA_LANES; g = g + 1) begin : lane
      always @(posedge clk) begin
        if (rst) begin
          word[g*8 +: 8] <= `ISPA_RST_BYTE;
        end else if (word_we) begin
          word[g*8 +: 8] <= word_in[g*8 +: 8];
        end else if (lane_we[g]) begin
          word[g*8 +: 8] <= byte_in;
        end
      end
    end
  endgenerate

endmodule

// ===== hdl/ispa_ptr.v
// The byte pointer of the peripheral space and its walk after every byte.
`timescale 1ns/100ps
`include "ispa_regs.vh"

module ispa_ptr (
  input wire clk,
  input wire rst,
  input wire load,
  input wire [7:0] load_value,
  input wire step,
  input wire step_write,
  output reg [7:0] ptr
);

  reg [7:0] next_ptr;

  // Next pointer after one byte; top bytes of the data windows fold back.
  always @* begin
    next_ptr = ptr + `ISPA_PTR_STEP;
    if (step_write && ptr == `ISPA_PTR_WDATA_MSB) begin
      next_ptr = `ISPA_PTR_WDATA;
    end else if (!step_write && ptr == `ISPA_PTR_RDATA_MSB) begin
      next_ptr = `ISPA_PTR_RDATA;
    end else if (ptr == `ISPA_PTR_LAST) begin
      next_ptr = `ISPA_PTR_FIRST;
    end
  end

  // A pointer byte from the master wins over a step in the same cycle.
  always @(posedge clk) begin
    if (rst) begin
      ptr <= `ISPA_PTR_FIRST;
    end else if (load) begin
      ptr <= load_value;
    end else if (step) begin
      ptr <= next_ptr;
    end
  end

endmodule

// ===== hdl/ispa_top.v
// Peripheral byte space behind the serial slave port, with indirect register-bus access.
//
// Contract
// - Bytes 0x00-0x03 hold aligned indirect write address.
// - Bytes 0x04-0x07 data; top byte launches bus write.
// - After writing 0x07 pointer returns to 0x04.
// - Reading 0x07 is plain; pointer goes 0x08.
// - Bytes 0x10-0x13 hold aligned indirect read address.
// - Reading 0x14 fetches word first, then returns byte.
// - After reading 0x17 pointer returns to 0x14.
// - Writing 0x17 does nothing; pointer goes 0x18.
// - Unmapped ranges are read-only.
// - Bytes 0x20-0x23 show access, mailbox, alert status.
// - Bytes 0x24-0x27 hold indirect access control.
// - Bytes 0x80-0x83 show internal status summary.
// - Enables at 0x84-0x87 gate summary bits onto alert.
// - Outbound mailbox 0x90-0x93 loaded inside, read outside.
// - Inbound mailbox 0x94-0x97 written by external master.
// - Pointer advances by one after all other bytes.
// - Unmapped reads give zero; writes only advance.
// - Lowest pointer selects least significant byte.
// - Hold serial clock low during pending bus access.
`timescale 1ns/100ps
`include "ispa_regs.vh"

module ispa_top (
  input wire clk,
  input wire rst,
  input wire ptr_load,
  input wire [7:0] ptr_value,
  input wire wr_stb,
  input wire [7:0] wr_byte,
  input wire rd_stb,
  output reg [7:0] rd_byte,
  output reg xfer_done,
  output reg scl_hold,
  output reg bus_req,
  output reg bus_we,
  output reg [31:0] bus_addr,
  output reg [31:0] bus_wdata,
  input wire bus_ack,
  input wire [31:0] bus_rdata,
  input wire [31:0] status_in,
  input wire mbox_out_load,
  input wire [31:0] mbox_out_value,
  input wire mbox_in_clear,
  output reg [31:0] inbound_mailbox,
  output reg mbox_in_full,
  output reg [31:0] access_control,
  output reg alert_flag,
  output reg [7:0] byte_pointer
);

  // Sequencer states: waiting for a byte, or waiting on the register bus.
  localparam [1:0] ST_IDLE = 2'b00;
  localparam [1:0] ST_WR_BUS = 2'b01;
  localparam [1:0] ST_RD_BUS = 2'b10;

  reg [1:0] state;
  reg [31:0] status_summary;
  reg [31:0] outbound_mailbox;
  reg [31:0] indirect_read_data;
  reg mbox_out_full;
  reg [31:0] external_access_status;
  reg [7:0] read_byte;
  reg ptr_step;
  reg ptr_step_write;

  wire [7:0] ptr;
  wire [31:0] indirect_write_address;
  wire [31:0] indirect_write_data;
  wire [31:0] indirect_read_address;
  wire [31:0] control_word;
  wire [31:0] status_alert_enables;
  wire [31:0] inbound_word;
  wire idle;
  wire byte_write;
  wire byte_read;
  wire [31:0] assembled_word;

  // Lane mask of the byte at pointer p inside the word based at base.
  function [3:0] ispa_lanes;
    input [7:0] p;
    input [7:0] base;
    begin
      if (p[7:2] == base[7:2]) begin
        ispa_lanes = `ISPA_LANE_ONE << p[1:0];
      end else begin
        ispa_lanes = `ISPA_LANE_NONE;
      end
    end
  endfunction

  // Byte of a word picked by the low pointer bits, least significant first.
  function [7:0] ispa_pick;
    input [31:0] w;
    input [1:0] lane;
    begin
      ispa_pick = w[lane*8 +: 8];
    end
  endfunction

  // True when pointer p falls in the word based at base.
  function ispa_hit;
    input [7:0] p;
    input [7:0] base;
    begin
      ispa_hit = (ispa_lanes(p, base) != `ISPA_LANE_NONE);
    end
  endfunction

  // Bytes are only accepted while no bus access is pending.
  assign idle = (state == ST_IDLE);
  assign byte_write = idle && wr_stb && !ptr_load;
  assign byte_read = idle && rd_stb && !ptr_load && !wr_stb;

  // The word as it will stand once the arriving top byte is in place.
  assign assembled_word = {wr_byte, indirect_write_data[23:0]};

  // Pointer register and its walk.
  ispa_ptr u_ptr (
    .clk(clk),
    .rst(rst),
    .load(ptr_load),
    .load_value(ptr_value),
    .step(ptr_step),
    .step_write(ptr_step_write),
    .ptr(ptr)
  );

  // Indirect write address, written byte by byte.
  ispa_word u_waddr (
    .clk(clk),
    .rst(rst),
    .lane_we(byte_write ? ispa_lanes(ptr, `ISPA_PTR_WADDR) : `ISPA_LANE_NONE),
    .byte_in(wr_byte),
    .word_we(1'b0),
    .word_in(`ISPA_RST_WORD),
    .q(indirect_write_address)
  );

  // Indirect write data holding register.
  ispa_word u_wdata (
    .clk(clk),
    .rst(rst),
    .lane_we(byte_write ? ispa_lanes(ptr, `ISPA_PTR_WDATA) : `ISPA_LANE_NONE),
    .byte_in(wr_byte),
    .word_we(1'b0),
    .word_in(`ISPA_RST_WORD),
    .q(indirect_write_data)
  );

  // Indirect read address, written byte by byte.
  ispa_word u_raddr (
    .clk(clk),
    .rst(rst),
    .lane_we(byte_write ? ispa_lanes(ptr, `ISPA_PTR_RADDR) : `ISPA_LANE_NONE),
    .byte_in(wr_byte),
    .word_we(1'b0),
    .word_in(`ISPA_RST_WORD),
    .q(indirect_read_address)
  );

  // Control word steering the indirect accesses.
  ispa_word u_ctrl (
    .clk(clk),
    .rst(rst),
    .lane_we(byte_write ? ispa_lanes(ptr, `ISPA_PTR_ACC_CTRL) : `ISPA_LANE_NONE),
    .byte_in(wr_byte),
    .word_we(1'b0),
    .word_in(`ISPA_RST_WORD),
    .q(control_word)
  );

  // Per-bit enables of the status summary onto the alert flag.
  ispa_word u_enables (
    .clk(clk),
    .rst(rst),
    .lane_we(byte_write ? ispa_lanes(ptr, `ISPA_PTR_ENABLES) : `ISPA_LANE_NONE),
    .byte_in(wr_byte),
    .word_we(1'b0),
    .word_in(`ISPA_RST_WORD),
    .q(status_alert_enables)
  );

  // Inbound mailbox, filled by the external master.
  ispa_word u_mbox_in (
    .clk(clk),
    .rst(rst),
    .lane_we(byte_write ? ispa_lanes(ptr, `ISPA_PTR_MBOX_IN) : `ISPA_LANE_NONE),
    .byte_in(wr_byte),
    .word_we(1'b0),
    .word_in(`ISPA_RST_WORD),
    .q(inbound_word)
  );

  // Status word seen by the master: flags and the current pointer.
  always @* begin
    external_access_status = `ISPA_RST_WORD;
    external_access_status[`ISPA_AS_ALERT] = alert_flag;
    external_access_status[`ISPA_AS_IN_FULL] = mbox_in_full;
    external_access_status[`ISPA_AS_OUT_FULL] = mbox_out_full;
    external_access_status[`ISPA_AS_PTR_LSB +: 8] = ptr;
  end

  // Read multiplexer; every byte outside a mapped word reads as zero.
  always @* begin
    read_byte = `ISPA_UNMAPPED_BYTE;
    if (ispa_hit(ptr, `ISPA_PTR_WADDR)) begin
      read_byte = ispa_pick(indirect_write_address, ptr[1:0]);
    end else if (ispa_hit(ptr, `ISPA_PTR_WDATA)) begin
      read_byte = ispa_pick(indirect_write_data, ptr[1:0]);
    end else if (ispa_hit(ptr, `ISPA_PTR_RADDR)) begin
      read_byte = ispa_pick(indirect_read_address, ptr[1:0]);
    end else if (ispa_hit(ptr, `ISPA_PTR_RDATA)) begin
      read_byte = ispa_pick(indirect_read_data, ptr[1:0]);
    end else if (ispa_hit(ptr, `ISPA_PTR_ACC_STAT)) begin
      read_byte = ispa_pick(external_access_status, ptr[1:0]);
    end else if (ispa_hit(ptr, `ISPA_PTR_ACC_CTRL)) begin
      read_byte = ispa_pick(control_word, ptr[1:0]);
    end else if (ispa_hit(ptr, `ISPA_PTR_SUMMARY)) begin
      read_byte = ispa_pick(status_summary, ptr[1:0]);
    end else if (ispa_hit(ptr, `ISPA_PTR_ENABLES)) begin
      read_byte = ispa_pick(status_alert_enables, ptr[1:0]);
    end else if (ispa_hit(ptr, `ISPA_PTR_MBOX_OUT)) begin
      read_byte = ispa_pick(outbound_mailbox, ptr[1:0]);
    end else if (ispa_hit(ptr, `ISPA_PTR_MBOX_IN)) begin
      read_byte = ispa_pick(inbound_word, ptr[1:0]);
    end
  end

  // Pointer step: after a plain byte at once, after a bus access on its ack.
  always @* begin
    ptr_step = 1'b0;
    ptr_step_write = 1'b0;
    if (byte_write && ptr != `ISPA_PTR_WDATA_MSB) begin
      ptr_step = 1'b1;
      ptr_step_write = 1'b1;
    end else if (byte_read && ptr != `ISPA_PTR_RDATA) begin
      ptr_step = 1'b1;
    end else if (state == ST_WR_BUS && bus_ack) begin
      ptr_step = 1'b1;
      ptr_step_write = 1'b1;
    end else if (state == ST_RD_BUS && bus_ack) begin
      ptr_step = 1'b1;
    end
  end

  // Sequencer for byte answers and register-bus cycles.
  always @(posedge clk) begin
    if (rst) begin
      state <= ST_IDLE;
      rd_byte <= `ISPA_RST_BYTE;
      xfer_done <= 1'b0;
      scl_hold <= 1'b0;
      bus_req <= 1'b0;
      bus_we <= 1'b0;
      bus_addr <= `ISPA_RST_WORD;
      bus_wdata <= `ISPA_RST_WORD;
      indirect_read_data <= `ISPA_RST_WORD;
    end else begin
      xfer_done <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (byte_write && ptr == `ISPA_PTR_WDATA_MSB) begin
            bus_req <= 1'b1;
            bus_we <= 1'b1;
            bus_addr <= indirect_write_address & `ISPA_ALIGN_MASK;
            bus_wdata <= assembled_word;
            scl_hold <= 1'b1;
            state <= ST_WR_BUS;
          end else if (byte_read && ptr == `ISPA_PTR_RDATA) begin
            bus_req <= 1'b1;
            bus_we <= 1'b0;
            bus_addr <= indirect_read_address & `ISPA_ALIGN_MASK;
            scl_hold <= 1'b1;
            state <= ST_RD_BUS;
          end else if (byte_read) begin
            rd_byte <= read_byte;
            xfer_done <= 1'b1;
          end else if (byte_write) begin
            xfer_done <= 1'b1;
          end
        end
        ST_WR_BUS: begin
          if (bus_ack) begin
            bus_req <= 1'b0;
            bus_we <= 1'b0;
            scl_hold <= 1'b0;
            xfer_done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_RD_BUS: begin
          if (bus_ack) begin
            indirect_read_data <= bus_rdata;
            rd_byte <= bus_rdata[7:0];
            bus_req <= 1'b0;
            scl_hold <= 1'b0;
            xfer_done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: begin
          bus_req <= 1'b0;
          scl_hold <= 1'b0;
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // Summary sampling, alert gating and the outbound mailbox.
  always @(posedge clk) begin
    if (rst) begin
      status_summary <= `ISPA_RST_WORD;
      alert_flag <= 1'b0;
      outbound_mailbox <= `ISPA_RST_WORD;
    end else begin
      status_summary <= status_in;
      alert_flag <= |(status_summary & status_alert_enables);
      if (mbox_out_load) begin
        outbound_mailbox <= mbox_out_value;
      end
    end
  end

  // Mailbox full flags; a set in the same cycle as a clear wins.
  always @(posedge clk) begin
    if (rst) begin
      mbox_out_full <= 1'b0;
      mbox_in_full <= 1'b0;
    end else begin
      if (mbox_out_load) begin
        mbox_out_full <= 1'b1;
      end else if (byte_read && ptr == `ISPA_PTR_MBOX_OUT_MSB) begin
        mbox_out_full <= 1'b0;
      end
      if (byte_write && ptr == `ISPA_PTR_MBOX_IN_MSB) begin
        mbox_in_full <= 1'b1;
      end else if (mbox_in_clear) begin
        mbox_in_full <= 1'b0;
      end
    end
  end

  // Registered copies of state shown to the rest of the device.
  always @(posedge clk) begin
    if (rst) begin
      inbound_mailbox <= `ISPA_RST_WORD;
      access_control <= `ISPA_RST_WORD;
      byte_pointer <= `ISPA_PTR_FIRST;
    end else begin
      inbound_mailbox <= inbound_word;
      access_control <= control_word;
      byte_pointer <= ptr;
    end
  end

endmodule

// ===== verif/ispa_assertions.sv
// Checker of the byte port, pointer walk and bus handshake.
`timescale 1ns/100ps
module ispa_chk (
  input wire clk,
  input wire rst,
  input wire ptr_load,
  input wire wr_stb,
  input wire rd_stb,
  input wire [7:0] rd_byte,
  input wire xfer_done,
  input wire scl_hold,
  input wire bus_req,
  input wire bus_we,
  input wire [31:0] bus_addr,
  input wire bus_ack,
  input wire [31:0] bus_rdata,
  input wire [7:0] byte_pointer
);
  reg prev_stb;
  wire quiet;
  wire wgo;
  wire rgo;

  // Notes a strobe of the last cycle, as the pointer copy lags by one.
  always @(posedge clk) begin
    if (rst) begin
      prev_stb <= 1'b0;
    end else begin
      prev_stb <= ptr_load | wr_stb | rd_stb;
    end
  end

  // A byte is judged only when the exported pointer is current.
  assign quiet = !prev_stb && !xfer_done && !ptr_load && !scl_hold;
  assign wgo = quiet && wr_stb;
  assign rgo = quiet && rd_stb && !wr_stb;

  // True for pointers that map to no register.
  function automatic logic unmapped(input logic [7:0] p);
    unmapped = p[7:3] == 5'h01 || p[7:3] == 5'h03 || (p[7:3] >= 5'h05 && p[7:3] <= 5'h0F) ||
      p[7:3] == 5'h11 || p[7:3] >= 5'h13;
  endfunction

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // The byte completes, then the pointer copy shows its new value.
  sequence s_walk(logic [7:0] e);
    xfer_done ##1 byte_pointer == e;
  endsequence

  AST_WR_LAUNCH: assert property (wgo && byte_pointer == 8'h07 |=> bus_req && bus_we)
    else $error("top data byte started no bus write");
  AST_WR_RETURN: assert property (bus_req && bus_we && bus_ack |=> s_walk(8'h04))
    else $error("pointer did not return to the data base");
  AST_RD_FETCH: assert property (rgo && byte_pointer == 8'h14 |=> bus_req && !bus_we)
    else $error("read of low data byte started no fetch");
  AST_RD_DATA: assert property (bus_req && !bus_we && bus_ack |=>
    xfer_done && rd_byte == $past(bus_rdata[7:0]))
    else $error("fetched low byte not returned");
  AST_RD_WRAP: assert property (rgo && byte_pointer == 8'h17 |=> s_walk(8'h14))
    else $error("pointer did not return to the read data base");
  AST_STEP: assert property (((wgo && byte_pointer != 8'h07) ||
    (rgo && byte_pointer != 8'h14 && byte_pointer != 8'h17)) && byte_pointer != 8'hFF
    |=> s_walk($past(byte_pointer, 2) + 8'h01))
    else $error("pointer did not step by one");
  AST_WRAP: assert property ((wgo || rgo) && byte_pointer == 8'hFF |=> s_walk(8'h00))
    else $error("pointer did not wrap");
  AST_ZERO: assert property (rgo && unmapped(byte_pointer) |=> xfer_done && rd_byte == 8'h00)
    else $error("unmapped read not zero");
  AST_HOLD: assert property (bus_req && !bus_ack |=> bus_req && scl_hold && $stable(bus_addr))
    else $error("request or clock hold dropped early");
  AST_ALIGN: assert property (bus_req |-> bus_addr[1:0] == 2'b00)
    else $error("bus address not word aligned");
endmodule

bind ispa_top ispa_chk u_chk (.clk(clk), .rst(rst), .ptr_load(ptr_load), .wr_stb(wr_stb),
  .rd_stb(rd_stb), .rd_byte(rd_byte), .xfer_done(xfer_done), .scl_hold(scl_hold),
  .bus_req(bus_req), .bus_we(bus_we), .bus_addr(bus_addr), .bus_ack(bus_ack),
  .bus_rdata(bus_rdata), .byte_pointer(byte_pointer));

// ===== verif/ispa_master_model.sv
// Behavioural external master handing single bytes to the slave port.
`timescale 1ns/100ps
module ispa_master_model (
  input wire clk,
  input wire xfer_done,
  input wire [7:0] rd_byte,
  output reg ptr_load,
  output reg [7:0] ptr_value,
  output reg wr_stb,
  output reg [7:0] wr_byte,
  output reg rd_stb
);
  // Bytes that never saw xfer_done within the wait limit.
  integer n_lost = 0;
  // All strobes start idle.
  initial begin
    ptr_load = 1'b0;
    ptr_value = 8'h00;
    wr_stb = 1'b0;
    wr_byte = 8'h00;
    rd_stb = 1'b0;
  end

  // Kind 0 sets the pointer, 1 writes, 2 reads; released data shows its inverse.
  task automatic xfer(input integer kind, input logic [7:0] b, output logic [7:0] r);
    integer n;
    begin
      n = 0;
      r = 8'hxx;
      @(negedge clk);
      ptr_load <= (kind == 0);
      ptr_value <= b;
      wr_stb <= (kind == 1);
      wr_byte <= b;
      rd_stb <= (kind == 2);
      @(negedge clk);
      ptr_load <= 1'b0;
      wr_stb <= 1'b0;
      rd_stb <= 1'b0;
      ptr_value <= ~b;
      wr_byte <= ~b;
      while (kind != 0 && xfer_done !== 1'b1 && n < 64) begin
        @(negedge clk);
        n = n + 1;
      end
      if (xfer_done === 1'b1) begin
        r = rd_byte;
      end else if (kind != 0) begin
        n_lost = n_lost + 1;
      end
    end
  endtask
endmodule

// ===== verif/ispa_top_tb.sv
// Self-checking bench of the peripheral byte space.
`timescale 1ns/100ps
module ispa_top_tb;
  reg clk;
  reg rst = 1'b1;
  reg bus_ack = 1'b0;
  reg mbox_out_load = 1'b0;
  reg mbox_in_clear = 1'b0;
  reg got_we = 1'b0;
  reg [31:0] bus_rdata = 32'h0000_0000;
  reg [31:0] status_in = 32'h0000_0000;
  reg [31:0] mbox_out_value = 32'h0000_0000;
  reg [31:0] got_addr = 32'h0000_0000;
  reg [31:0] got_data = 32'h0000_0000;
  reg [31:0] w;
  reg [7:0] r;
  integer n_errors = 0;
  integer cmp_count = 0;
  integer ack_delay = 0;
  integer dly = 0;
  integer n_acks = 0;
  integer i;
  wire ptr_load, wr_stb, rd_stb, xfer_done, scl_hold, bus_req, bus_we, mbox_in_full, alert_flag;
  wire [7:0] ptr_value, wr_byte, rd_byte, byte_pointer;
  wire [31:0] bus_addr, bus_wdata, inbound_mailbox, access_control;
  localparam [39:0] RW_BASES = {8'h00, 8'h10, 8'h24, 8'h84, 8'h94};
  localparam [79:0] HOLES = {8'hFF, 8'h98, 8'h8C, 8'h88, 8'h7F, 8'h28, 8'h1F, 8'h18, 8'h0C, 8'h08};

  // The clock runs at 10 MHz.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  ispa_top uut (.clk(clk), .rst(rst), .ptr_load(ptr_load), .ptr_value(ptr_value),
    .wr_stb(wr_stb), .wr_byte(wr_byte), .rd_stb(rd_stb), .rd_byte(rd_byte),
    .xfer_done(xfer_done), .scl_hold(scl_hold), .bus_req(bus_req), .bus_we(bus_we),
    .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_ack(bus_ack), .bus_rdata(bus_rdata),
    .status_in(status_in), .mbox_out_load(mbox_out_load), .mbox_out_value(mbox_out_value),
    .mbox_in_clear(mbox_in_clear), .inbound_mailbox(inbound_mailbox),
    .mbox_in_full(mbox_in_full), .access_control(access_control), .alert_flag(alert_flag),
    .byte_pointer(byte_pointer));

  ispa_master_model m (.clk(clk), .xfer_done(xfer_done), .rd_byte(rd_byte),
    .ptr_load(ptr_load), .ptr_value(ptr_value), .wr_stb(wr_stb), .wr_byte(wr_byte),
    .rd_stb(rd_stb));

  // Register-bus slave: acknowledges after ack_delay cycles; idle data toggles.
  always @(negedge clk) begin
    bus_ack <= 1'b0;
    bus_rdata <= ~bus_rdata;
    if (bus_req === 1'b1 && bus_ack === 1'b0 && dly < ack_delay) begin
      dly <= dly + 1;
    end else if (bus_req === 1'b1 && bus_ack === 1'b0) begin
      dly <= 0;
      bus_ack <= 1'b1;
      bus_rdata <= 32'h5A3C_0000 + n_acks;
      n_acks <= n_acks + 1;
      got_addr <= bus_addr;
      got_data <= bus_wdata;
      got_we <= bus_we;
    end
  end

  task check(input [31:0] seen, input [31:0] exp);
    begin
      cmp_count = cmp_count + 1;
      if (seen !== exp) begin
        n_errors = n_errors + 1;
        $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task complete_run;
    begin
      n_errors = n_errors + m.n_lost;
      $display("Compares %0d, mismatches %0d", cmp_count, n_errors);
      if (n_errors == 0 && cmp_count > 0) begin
        $display("Run complete: PASS");
      end else begin
        $display("Run complete: FAIL");
      end
      $finish;
    end
  endtask

  task settle;
    @(negedge clk);
  endtask

  task put(input [7:0] p);
    m.xfer(0, p, r);
  endtask

  task wr_word(input [7:0] p, input [31:0] d);
    integer k;
    begin
      put(p);
      for (k = 0; k < 4; k = k + 1) begin
        m.xfer(1, d[8*k +: 8], r);
      end
    end
  endtask

  task rd_word(input [7:0] p, output [31:0] d);
    integer k;
    begin
      put(p);
      for (k = 0; k < 4; k = k + 1) begin
        m.xfer(2, 8'h00, r);
        d[8*k +: 8] = r;
      end
    end
  endtask

  // Writable words: zero after reset, then read back what was written.
  task t_regs;
    begin
      for (i = 0; i < 5; i = i + 1) begin
        rd_word(RW_BASES[8*i +: 8], w);
        check(w, 32'h0000_0000);
        wr_word(RW_BASES[8*i +: 8], 32'hC4B3_A291 + i);
        rd_word(RW_BASES[8*i +: 8], w);
        check(w, 32'hC4B3_A291 + i);
      end
      check(access_control, 32'hC4B3_A293);
      check(inbound_mailbox, 32'hC4B3_A291);
      check(mbox_in_full, 1'b1);
      put(8'h20);
      m.xfer(2, 8'h00, r);
      check(r, 8'h02);
      mbox_in_clear = 1'b1;
      settle;
      mbox_in_clear = 1'b0;
      settle;
      check(mbox_in_full, 1'b0);
    end
  endtask

  // Indirect writes: slow then fast acknowledge, repeated word, top byte alone.
  task t_wbus;
    begin
      ack_delay = 3;
      wr_word(8'h00, 32'h0001_2347);
      wr_word(8'h04, 32'hDEAD_0001);
      check(got_addr, 32'h0001_2344);
      check(got_we, 1'b1);
      check(got_data, 32'hDEAD_0001);
      ack_delay = 0;
      for (i = 0; i < 4; i = i + 1) begin
        m.xfer(1, 8'hDF - 8'h44 * i, r);
      end
      check(got_data, 32'h1357_9BDF);
      settle;
      check(byte_pointer, 8'h04);
      put(8'h07);
      m.xfer(1, 8'hEE, r);
      check(got_data, 32'hEE57_9BDF);
      check(n_acks, 3);
    end
  endtask

  // Indirect reads: two fetched words in one run of eight bytes.
  task t_rbus;
    reg [63:0] e;
    begin
      ack_delay = 2;
      wr_word(8'h10, 32'h0000_0456);
      put(8'h14);
      e = {32'h5A3C_0004, 32'h5A3C_0003};
      for (i = 0; i < 8; i = i + 1) begin
        m.xfer(2, 8'h00, r);
        check(r, e[8*i +: 8]);
      end
      check(got_addr, 32'h0000_0454);
      check(got_we, 1'b0);
      check(n_acks, 5);
      settle;
      check(byte_pointer, 8'h14);
    end
  endtask

  // Pointer exceptions and the unmapped holes.
  task t_walk;
    begin
      put(8'h07);
      m.xfer(2, 8'h00, r);
      check(r, 8'hEE);
      settle;
      check(byte_pointer, 8'h08);
      put(8'h17);
      m.xfer(1, 8'h99, r);
      settle;
      check(byte_pointer, 8'h18);
      check(n_acks, 5);
      for (i = 0; i < 10; i = i + 1) begin
        put(HOLES[8*i +: 8]);
        m.xfer(1, 8'hA5, r);
        put(HOLES[8*i +: 8]);
        m.xfer(2, 8'h00, r);
        check(r, 8'h00);
      end
      settle;
      check(byte_pointer, 8'h00);
    end
  endtask

  // Summary, alert gating, outbound mailbox and its status bit.
  task t_status;
    begin
      status_in = 32'h8012_3456;
      repeat (3) settle;
      check(alert_flag, 1'b1);
      put(8'h20);
      m.xfer(2, 8'h00, r);
      check(r, 8'h01);
      rd_word(8'h80, w);
      check(w, 32'h8012_3456);
      wr_word(8'h84, 32'h0000_0000);
      repeat (2) settle;
      check(alert_flag, 1'b0);
      mbox_out_value = 32'h6B2D_91E4;
      mbox_out_load = 1'b1;
      settle;
      mbox_out_load = 1'b0;
      put(8'h20);
      m.xfer(2, 8'h00, r);
      check(r, 8'h04);
      put(8'h90);
      m.xfer(1, 8'h11, r);
      rd_word(8'h90, w);
      check(w, 32'h6B2D_91E4);
      put(8'h20);
      m.xfer(2, 8'h00, r);
      check(r, 8'h00);
    end
  endtask

  // Cuts a hang short.
  initial begin
    repeat (20000) @(posedge clk);
    n_errors = n_errors + 1;
    complete_run;
  end

  // Reset for 20 cycles, then the scenarios.
  initial begin
    repeat (20) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    t_regs;
    t_wbus;
    t_rbus;
    t_walk;
    t_status;
    complete_run;
  end
endmodule
